// ===== iod_pkg.sv
/*
 Constants for the instruction and operand decoder: opcode encodings,
 addressing-mode codes, register ranges, flag positions and shift limits.
 Assumes nothing of its surroundings; imported by the decoder modules.
*/
package iod_pkg;

   typedef enum logic [1:0] {
      IOD_MODE_DIRECT = 2'b00,
      IOD_MODE_IMMED  = 2'b01,
      IOD_MODE_INDIR  = 2'b10,
      IOD_MODE_INDEX  = 2'b11
   } iod_mode_e;

   typedef enum logic [2:0] {
      IOD_ST_IDLE  = 3'b000,
      IOD_ST_SRC   = 3'b001,
      IOD_ST_DST   = 3'b010,
      IOD_ST_EXEC  = 3'b011,
      IOD_ST_WRITE = 3'b100
   } iod_state_e;

   // Opcode byte 011001aa: the upper six bits identify the word add.
   localparam logic [5:0] IOD_OP_ADD2W      = 6'h19;
   localparam int         IOD_MODE_LSB      = 0;
   localparam int         IOD_MODE_W        = 2;
   // Group of opcodes that carry the mode field: 01xxxxaa and 10xxxxaa.
   localparam logic [1:0] IOD_GRP_ALU2      = 2'h1;
   localparam logic [1:0] IOD_GRP_ALU3      = 2'h2;
   localparam int         IOD_BITNO_LSB     = 0;
   localparam int         IOD_BITNO_W       = 3;

   localparam logic [7:0] IOD_SPF_FIRST     = 8'h10;
   localparam logic [7:0] IOD_SPF_LAST      = 8'h17;
   localparam logic [7:0] IOD_INDSH_FIRST   = 8'h18;
   localparam logic [7:0] IOD_INDSH_LAST    = 8'hFF;
   localparam int         IOD_SHCNT_W       = 5;
   localparam logic [4:0] IOD_SHCNT_MAX     = 5'h1F;

   // Flag vector positions.
   localparam int         IOD_F_Z           = 0;
   localparam int         IOD_F_N           = 1;
   localparam int         IOD_F_C           = 2;
   localparam int         IOD_F_V           = 3;
   localparam int         IOD_F_STKOVF      = 4;
   localparam int         IOD_F_STKSH       = 5;
   localparam int         IOD_FLAGS_W       = 6;
   localparam logic [5:0] IOD_FLAGS_RST     = 6'h00;
   localparam logic [15:0] IOD_PC_RST       = 16'h2080;

   // Byte lengths of the two-operand word add per addressing mode.
   localparam logic [15:0] IOD_LEN_DIRECT   = 16'h0003;
   localparam logic [15:0] IOD_LEN_IMMED    = 16'h0004;
   localparam logic [15:0] IOD_LEN_INDIR    = 16'h0003;
   localparam logic [15:0] IOD_LEN_INDEX    = 16'h0004;

endpackage

// ===== iod_field_dec.sv
/*
 Combinational field decoder for one opcode byte: mode field, bit number,
 shift-count source class and the truncated count.
 Assumes the opcode and count register number come from the same clock.
*/
`timescale 1ns/1ps
module iod_field_dec
   import iod_pkg::*;
(
   input  wire logic [7:0]  opcode,
   input  wire logic [7:0]  cnt_src,
   input  wire logic [7:0]  cnt_val,
   output wire logic        has_mode,
   output wire iod_mode_e   addr_mode_field,
   output wire logic [7:0]  bit_sel,
   output wire logic        cnt_indirect,
   output wire logic        cnt_illegal,
   output wire logic [4:0]  shift_cnt
);

   wire logic [1:0] grp;

   assign grp             = opcode[7:6];
   assign has_mode        = (grp == IOD_GRP_ALU2)
                          || (grp == IOD_GRP_ALU3);
   assign addr_mode_field = has_mode
                          ? iod_mode_e'(opcode[IOD_MODE_LSB +: IOD_MODE_W])
                          : IOD_MODE_DIRECT;
   assign bit_sel         = 8'h01
                          << opcode[IOD_BITNO_LSB +: IOD_BITNO_W];
   assign cnt_indirect    = cnt_src >= IOD_INDSH_FIRST;
   assign cnt_illegal     = (cnt_src >= IOD_SPF_FIRST)
                          && (cnt_src <= IOD_SPF_LAST);
   // A direct count under 16 is the register number itself.
   assign shift_cnt       = cnt_indirect ? cnt_val[IOD_SHCNT_W-1:0]
                          : cnt_src[IOD_SHCNT_W-1:0];

endmodule

// ===== iod_core.sv
/*
 Operand decode and two-operand word add sequencer with flag update and
 program-counter advance.
 Assumes program bytes arrive one per fetch strobe on the core clock and
 that the register file answers a read in the same cycle it is addressed.
*/
// How it works
// - After a word add the counter moves on by its byte length; other opcodes leave it.
// - Mode field 00, 01, 10, 11 mean direct, immediate, indirect, indexed.
// - Only opcodes with a mode choice carry the mode field.
// - A three-bit bit number picks one of eight bits in a byte.
// - Byte, word and long registers all live in the register file.
// - A flag the instruction leaves alone keeps its old value.
// - A sticky flag may be set but never cleared by the instruction.
// - A clear-only flag may be cleared but never set.
// - An undefined flag may hold any value afterwards.
// - Indirect shift counts come from registers 24 to 255.
// - Shift counts keep only their low five bits.
// - Word add writes dest plus source, sets Z, N, C, V, sticky overflow.
// - Word add is 011001aa, then source operand, then destination byte.
`timescale 1ns/1ps
module iod_core
   import iod_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        fetch_valid,
   input  wire logic [7:0]  fetch_byte,
   input  wire logic [15:0] src_operand,
   input  wire logic [15:0] rf_rdata,
   input  wire logic [7:0]  cnt_src,
   input  wire logic [7:0]  cnt_val,
   output logic [15:0]      pc_reg,
   output logic [5:0]       flags_reg,
   output logic [7:0]       rf_addr_reg,
   output logic [15:0]      rf_wdata_reg,
   output logic             rf_we_reg,
   output logic [1:0]       mode_reg,
   output logic             busy_reg,
   output logic [7:0]       bit_sel_reg,
   output logic [4:0]       shift_cnt_reg,
   output logic             cnt_indirect_reg,
   output logic             cnt_illegal_reg,
   output logic             unknown_op_reg
);

   iod_state_e    state_reg;
   iod_state_e    state_next;
   logic [15:0]   dst_val_reg;
   logic [15:0]   src_val_reg;
   logic [15:0]   len_reg;

   wire logic       has_mode;
   wire iod_mode_e  mode_dec;
   wire logic [7:0] bit_sel;
   wire logic       cnt_ind;
   wire logic       cnt_ill;
   wire logic [4:0] shift_cnt;
   wire logic       is_add;
   wire logic [16:0] sum;
   wire logic        ovf;
   wire logic [5:0]  flags_next;
   wire logic [15:0] len_dec;

   iod_field_dec u_dec (
      .opcode          (fetch_byte),
      .cnt_src         (cnt_src),
      .cnt_val         (cnt_val),
      .has_mode        (has_mode),
      .addr_mode_field (mode_dec),
      .bit_sel         (bit_sel),
      .cnt_indirect    (cnt_ind),
      .cnt_illegal     (cnt_ill),
      .shift_cnt       (shift_cnt)
   );

   function automatic logic [15:0] add_len(input iod_mode_e m);
      case (m)
         IOD_MODE_DIRECT: add_len = IOD_LEN_DIRECT;
         IOD_MODE_IMMED:  add_len = IOD_LEN_IMMED;
         IOD_MODE_INDIR:  add_len = IOD_LEN_INDIR;
         default:         add_len = IOD_LEN_INDEX;
      endcase
   endfunction

   assign is_add  = has_mode && (fetch_byte[7:2] == IOD_OP_ADD2W);
   assign len_dec = add_len(mode_dec);
   assign sum     = {1'b0, dst_val_reg} + {1'b0, src_val_reg};
   assign ovf     = (dst_val_reg[15] == src_val_reg[15])
                  && (sum[15] != dst_val_reg[15]);
   // Sticky overflow only ORs in, shift sticky bit passes through.
   // No flag of the word add is clear-only or left undefined.
   assign flags_next[IOD_F_Z]  = (sum[15:0] == 16'h0000);
   assign flags_next[IOD_F_N]  = sum[15];
   assign flags_next[IOD_F_C]  = sum[16];
   assign flags_next[IOD_F_V]  = ovf;
   assign flags_next[IOD_F_STKOVF] = flags_reg[IOD_F_STKOVF] | ovf;
   assign flags_next[IOD_F_STKSH]  = flags_reg[IOD_F_STKSH];

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         IOD_ST_IDLE:  if (fetch_valid && is_add) state_next = IOD_ST_SRC;
         IOD_ST_SRC:   if (fetch_valid) state_next = IOD_ST_DST;
         IOD_ST_DST:   if (fetch_valid) state_next = IOD_ST_EXEC;
         IOD_ST_EXEC:  state_next = IOD_ST_WRITE;
         IOD_ST_WRITE: state_next = IOD_ST_IDLE;
         default:      state_next = IOD_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= IOD_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // The source value arrives resolved by the operand fetch unit, so one
   // byte slot stands for it regardless of the extra mode bytes.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_reg       <= IOD_MODE_DIRECT;
         len_reg        <= 16'h0000;
         src_val_reg    <= 16'h0000;
         dst_val_reg    <= 16'h0000;
         rf_addr_reg    <= 8'h00;
         unknown_op_reg <= 1'b0;
      end else begin
         if (state_reg == IOD_ST_IDLE && fetch_valid) begin
            mode_reg       <= mode_dec;
            len_reg        <= len_dec;
            unknown_op_reg <= !is_add;
         end
         if (state_reg == IOD_ST_SRC && fetch_valid) begin
            src_val_reg <= src_operand;
         end
         if (state_reg == IOD_ST_DST && fetch_valid) begin
            rf_addr_reg <= fetch_byte;
         end
         if (state_reg == IOD_ST_EXEC) begin
            dst_val_reg <= rf_rdata;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_reg       <= IOD_PC_RST;
         flags_reg    <= IOD_FLAGS_RST;
         rf_wdata_reg <= 16'h0000;
         rf_we_reg    <= 1'b0;
      end else begin
         rf_we_reg <= (state_reg == IOD_ST_WRITE);
         if (state_reg == IOD_ST_WRITE) begin
            rf_wdata_reg <= sum[15:0];
            flags_reg    <= flags_next;
            pc_reg       <= pc_reg + len_reg;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_reg         <= 1'b0;
         bit_sel_reg      <= 8'h00;
         shift_cnt_reg    <= 5'h00;
         cnt_indirect_reg <= 1'b0;
         cnt_illegal_reg  <= 1'b0;
      end else begin
         busy_reg         <= (state_next != IOD_ST_IDLE);
         bit_sel_reg      <= bit_sel;
         shift_cnt_reg    <= shift_cnt;
         cnt_indirect_reg <= cnt_ind;
         cnt_illegal_reg  <= cnt_ill;
      end
   end

endmodule

// ===== iod_asserts.sv
/* Port assertions for the operand decoder core.
   Assumes one clock domain and binding onto iod_core. */
`timescale 1ns/1ps
module iod_asserts
   import iod_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        fetch_valid,
   input wire logic [7:0]  fetch_byte,
   input wire logic [7:0]  cnt_src,
   input wire logic [7:0]  cnt_val,
   input wire logic [15:0] pc_reg,
   input wire logic [5:0]  flags_reg,
   input wire logic [15:0] rf_wdata_reg,
   input wire logic        rf_we_reg,
   input wire logic [1:0]  mode_reg,
   input wire logic        busy_reg,
   input wire logic [7:0]  bit_sel_reg,
   input wire logic [4:0]  shift_cnt_reg,
   input wire logic        cnt_indirect_reg,
   input wire logic        cnt_illegal_reg
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire logic [4:0] cnt_x = cnt_src >= 8'h18 ? cnt_val[4:0] : cnt_src[4:0];
   wire logic       ill_x = cnt_src inside {[8'h10:8'h17]};
   wire logic       ind_x = cnt_src >= 8'h18;
   wire logic [1:0] mod_x = fetch_byte[7:6] inside {2'h1, 2'h2} ?
                            fetch_byte[1:0] : 2'h0;
   wire logic [2:0] bno_x = fetch_byte[2:0];
   sequence op_seen;
      fetch_valid && !busy_reg;
   endsequence
   sequence add_seen;
      op_seen ##0 fetch_byte[7:2] == IOD_OP_ADD2W;
   endsequence
   mode_dec_a: assert property (
      op_seen |=> mode_reg == $past(mod_x))
      else $error("mode field decode wrong");
   bit_pick_a: assert property (
      fetch_valid |=> bit_sel_reg == 8'h01 << $past(bno_x))
      else $error("bit select wrong");
   cnt_trunc_a: assert property (
      1 |=> shift_cnt_reg == $past(cnt_x))
      else $error("shift count wrong");
   cnt_class_a: assert property (
      1 |=> cnt_illegal_reg == $past(ill_x) &&
      cnt_indirect_reg == $past(ind_x))
      else $error("count source class wrong");
   add_start_a: assert property (add_seen |=> busy_reg)
      else $error("word add not taken");
   we_pulse_a: assert property (rf_we_reg |=> !rf_we_reg)
      else $error("write strobe too long");
   hold_a: assert property (
      !rf_we_reg |-> $stable(flags_reg) && $stable(pc_reg))
      else $error("flags or pc moved without an add");
   shbit_keep_a: assert property (
      rf_we_reg |-> $stable(flags_reg[IOD_F_STKSH]))
      else $error("shift sticky flag changed");
   ovf_sticky_a: assert property (
      $past(flags_reg[IOD_F_STKOVF]) |-> flags_reg[IOD_F_STKOVF])
      else $error("sticky overflow cleared");
   ovf_from_v_a: assert property (
      rf_we_reg && flags_reg[IOD_F_V] |-> flags_reg[IOD_F_STKOVF])
      else $error("sticky overflow not set");
   zn_flag_a: assert property (
      rf_we_reg |-> flags_reg[IOD_F_Z] == (rf_wdata_reg == 16'h0000)
      && flags_reg[IOD_F_N] == rf_wdata_reg[15])
      else $error("zero or negative flag wrong");
   pc_step_a: assert property (
      rf_we_reg |-> pc_reg == $past(pc_reg) +
      (mode_reg[0] ? 16'h0004 : 16'h0003))
      else $error("pc advance wrong");
endmodule
bind iod_core iod_asserts u_iod_asserts (.clk, .rst_b, .fetch_valid,
   .fetch_byte, .cnt_src, .cnt_val, .pc_reg, .flags_reg, .rf_wdata_reg,
   .rf_we_reg, .mode_reg, .busy_reg, .bit_sel_reg, .shift_cnt_reg,
   .cnt_indirect_reg, .cnt_illegal_reg);

// ===== iod_rf_model.sv
/* Register file model behind the core, one word per register number.
   Assumes a one-cycle write strobe on the core clock. */
`timescale 1ns/1ps
module iod_rf_model
(
   input  wire logic        clk,
   input  wire logic [7:0]  rf_addr_reg,
   input  wire logic [15:0] rf_wdata_reg,
   input  wire logic        rf_we_reg,
   output wire logic [15:0] rf_rdata
);
   logic [15:0] mem [256];
   // Read is same-cycle, as the core expects of its register file.
   assign rf_rdata = mem[rf_addr_reg];
   initial for (int i = 0; i < 256; i++) mem[i] = {i[7:0], ~i[7:0]};
   always @(posedge clk)
      if (rf_we_reg) mem[rf_addr_reg] <= rf_wdata_reg;
endmodule

// ===== tb.sv
/* Self-checking bench for the decoder core and register file model.
   Assumes a 200 MHz clock and the model's initial register pattern. */
`timescale 1ns/1ps
module tb;
   logic        clk, rst_b, fv, we, bz, ci, cil, uo, sov;
   logic [7:0]  fb, cs, cv, ra, bs;
   logic [15:0] so, rd, pc, wd, pce, sh [256];
   logic [5:0]  fl, fe;
   logic [1:0]  md;
   logic [4:0]  sc;
   logic [7:0]  cl [5] = '{8'h0F, 8'h10, 8'h17, 8'h18, 8'hFF};
   int          errors = 0;
   int          num_checks = 0;
   iod_core u_iod_core (.clk, .rst_b, .fetch_valid(fv), .fetch_byte(fb),
      .src_operand(so), .rf_rdata(rd), .cnt_src(cs), .cnt_val(cv),
      .pc_reg(pc), .flags_reg(fl), .rf_addr_reg(ra), .rf_wdata_reg(wd),
      .rf_we_reg(we), .mode_reg(md), .busy_reg(bz), .bit_sel_reg(bs),
      .shift_cnt_reg(sc), .cnt_indirect_reg(ci), .cnt_illegal_reg(cil),
      .unknown_op_reg(uo));
   iod_rf_model u_iod_rf_model (.clk, .rf_addr_reg(ra), .rf_wdata_reg(wd),
      .rf_we_reg(we), .rf_rdata(rd));
   task chk(input logic [15:0] got, exp, input string nm);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task send(input logic [7:0] b);
      @(negedge clk);
      fv = 1;
      fb = b;
      @(posedge clk);
   endtask
   task add(input logic [1:0] m, input logic [7:0] d, input logic [15:0] s,
            input logic g);
      logic [16:0] r;
      logic        v;
      int          n;
      r = sh[d] + s;
      v = sh[d][15] == s[15] && r[15] != s[15];
      so = s;
      send({6'b011001, m});
      // A gap after the opcode shows the sequencer waits for the strobe.
      if (g) begin
         @(negedge clk);
         fv = 0;
         chk(16'(bz), 16'h0001, "busy");
      end
      send(8'h00);
      send(d);
      for (n = 1; n < 9 && we !== 1'b1; n++) begin
         @(negedge clk);
         fv = 0;
      end
      sov |= v;
      fe = {1'b0, sov, v, r[16], r[15], r[15:0] == 16'h0000};
      pce += m[0] ? 16'h0004 : 16'h0003;
      sh[d] = r[15:0];
      chk(16'(n), 16'h0004, "latency");
      chk(wd, r[15:0], "sum");
      chk(16'(ra), 16'(d), "dest");
      chk(16'(fl), 16'(fe), "flags");
      chk(pc, pce, "pc");
      chk(16'(md), 16'(m), "mode");
      chk(16'(uo), 16'h0000, "add known");
      chk(16'(bz), 16'h0000, "idle after add");
   endtask
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #20000;
      errors++;
      give_verdict;
   end
   initial begin
      logic [7:0]  d;
      logic [15:0] s;
      logic [15:0] ce;
      rst_b = 0;
      fv = 0;
      fb = 0;
      so = 0;
      cs = 0;
      cv = 0;
      sov = 0;
      pce = 16'h2080;
      foreach (sh[i]) sh[i] = {i[7:0], ~i[7:0]};
      repeat (6) @(negedge clk);
      rst_b = 1;
      chk(pc, pce, "pc reset");
      chk(16'(fl), 16'h0000, "flags reset");
      for (int m = 0; m < 4; m++)
         for (int k = 0; k < 4; k++) begin
            d = 8'h30 + 8'(m);
            s = k == 0 ? 16'h7FFF : k == 1 ? 16'hFFFF
              : k == 2 ? -sh[d] : 16'h0001;
            add(2'(m), d, s, k[0]);
         end
      for (int k = 0; k < 8; k++) begin
         send(8'hC0 | 8'(k));
         @(negedge clk);
         chk(16'(bs), 16'h0001 << k, "bit select");
         chk(16'(md), 16'h0000, "no mode");
         chk(16'(uo), 16'h0001, "unknown op");
      end
      send(8'h63);
      @(negedge clk);
      chk(16'(md), 16'h0003, "mode of other op");
      chk(16'(fl), 16'(fe), "flags kept");
      chk(pc, pce, "pc kept");
      foreach (cl[i]) begin
         cs = cl[i];
         cv = 8'hE6;
         @(negedge clk);
         ce = cl[i] >= 8'h18 ? 16'h0006 : 16'(cl[i][4:0]);
         chk(16'(sc), ce, "count");
         chk(16'(cil), 16'(cl[i] inside {[8'h10:8'h17]}), "illegal");
         chk(16'(ci), 16'(cl[i] >= 8'h18), "indirect");
      end
      give_verdict;
   end
endmodule
